/* hdl/fdc_map.svh */
`ifndef FDC_MAP_SVH
`define FDC_MAP_SVH

// Register byte offsets on the AXI4-Lite port.
`define FDC_OFF_CTRL      8'h00
`define FDC_OFF_STATUS    8'h04
`define FDC_OFF_FILL      8'h08
`define FDC_OFF_PTRS      8'h0c

// Control register fields and reset value.
`define FDC_CTRL_HOLD     0
`define FDC_CTRL_RESET    1'h0

// Status register field positions.
`define FDC_ST_EMPTY      0
`define FDC_ST_HALF       1
`define FDC_ST_FULL       2
`define FDC_ST_RDPEND     3
`define FDC_ST_WRPEND     4
`define FDC_ST_RFPEND     5
`define FDC_ST_IDLE       6

// Fill counter landmarks and counter reset values.
`define FDC_FILL_EMPTY    16'h0000
`define FDC_FILL_HALF     16'h7fff
`define FDC_FILL_FULL     16'hffff
`define FDC_CNT_RESET     16'h0000

// AXI response codes.
`define FDC_RESP_OKAY     2'h0
`define FDC_RESP_DECERR   2'h3

`endif

/* hdl/fdc_pkg.sv */
package fdc_pkg;

  // Sequencer states for access and refresh cycles.
  typedef enum logic [2:0] {
    FDC_IDLE,
    FDC_ROW,
    FDC_RAS,
    FDC_COL,
    FDC_CAS1,
    FDC_CAS2,
    FDC_RF1,
    FDC_RF2
  } fdc_state_t;

endpackage : fdc_pkg

/* hdl/fdc_controller.sv */
`timescale 1ns/1ps
`include "fdc_map.svh"

// Operation
// - Access cycles present row and drop row strobe before column address and strobe.
// - Refresh is column-before-row and beats any pending access.
// - No refresh address is generated; the memory counts refresh rows itself.
// - Separate 16-bit write and read pointers muxed onto the memory address.
// - A 16-bit up/down fill counter yields full, empty and half-full flags.
// - Each granted access pulses access_enable, which steps the fill counter.
// - Row, column, write and output strobes are active low, idle high.
// - Arbiter order is refresh, then write, then read.
// - Read grant waits for every pending refresh and write.
// - Write grant waits for a pending refresh.
// - Refresh request holds both ready outputs low until refresh completes.
// - Each captured request is cleared when its cycle finishes.
// - With nothing pending, row strobe, row_col_select and column strobe stay high.
// - Write ready stays low for the whole write; requester waits for it.
// - Write edge one places write pointer row bits on the address.
// - Write edge two drops the row strobe.
// - Write edge three selects column address and drops write enable early.
// - Write edge four drops the column strobe with write enable low.
// - Write enable low 1.5 cycles, column strobe low two, row strobe four; strobes release together, ready rises.
// - Reads share write timing; write enable high, output enable low after row strobe.
// - Refresh: column strobe low edge one, row edge two, both release edge three.
// - Fill counts up on writes, down on reads; flags at 0000, ffff, 7fff.
// - row_col_select high drives row bits, low drives column bits.
module fdc_controller (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Requester pins.
  input  wire logic        read_request_n,
  input  wire logic        write_request_n,
  input  wire logic        refresh_request,
  output      logic        readReady_o,
  output      logic        writeReady_o,
  output      logic        accessEnable_o,
  // Buffer status flags.
  output      logic        fifoFull_o,
  output      logic        fifoEmpty_o,
  output      logic        fifoHalf_o,
  // Memory array.
  output      logic [7:0]  memAddr_o,
  output      logic        rowColSel_o,
  output      logic        rasN_o,
  output      logic        casN_o,
  output      logic        weN_o,
  output      logic        oeN_o,
  // AXI4-Lite slave.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  fdc_pkg::fdc_state_t state_r, state_nxt;
  logic [2:0]  sync1_r, sync2_r, sync3_r;
  logic        rdPend_r, rdPend_nxt, wrPend_r, wrPend_nxt, rfPend_r, rfPend_nxt;
  logic        opWrite_r, opWrite_nxt, accEn_r, accEn_nxt;
  logic [15:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt, fill_r, fill_nxt;
  logic [7:0]  addr_r, addr_nxt;
  logic        ras_r, ras_nxt, cas_r, cas_nxt, rcs_r, rcs_nxt, oe_r, oe_nxt;
  logic        weP_r, weP_nxt, weNeg_r, weNeg_nxt;
  logic        rdy_r, rdy_nxt, wrdy_r, wrdy_nxt;
  logic        full_r, full_nxt, empty_r, empty_nxt, half_r, half_nxt;
  logic        hold_r, hold_nxt;
  logic        rdEvt, wrEvt, rfEvt, done, doneRf;
  logic [15:0] ptrNxt;

  // Pins cross in through two flops; the third stage only feeds edge detection.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync1_r <= 3'h3;
      sync2_r <= 3'h3;
      sync3_r <= 3'h3;
    end else begin
      sync1_r <= {refresh_request, write_request_n, read_request_n};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // Request events: falling request pins, rising refresh request.
  assign rdEvt  = !sync2_r[0] && sync3_r[0];
  assign wrEvt  = !sync2_r[1] && sync3_r[1];
  assign rfEvt  = sync2_r[2] && !sync3_r[2];
  assign done   = (state_r == fdc_pkg::FDC_CAS2);
  assign doneRf = (state_r == fdc_pkg::FDC_RF2);

  // Request capture, arbitration and strobe sequencing.
  always_comb begin
    state_nxt   = state_r;
    opWrite_nxt = opWrite_r;
    accEn_nxt   = 1'b0;
    wrPtr_nxt   = wrPtr_r;
    rdPtr_nxt   = rdPtr_r;
    // A new event in the clearing cycle wins, so no request is lost.
    rdPend_nxt  = rdEvt || (rdPend_r && !(done && !opWrite_r));
    wrPend_nxt  = wrEvt || (wrPend_r && !(done && opWrite_r));
    rfPend_nxt  = rfEvt || (rfPend_r && !doneRf);
    unique case (state_r)
      fdc_pkg::FDC_IDLE: begin
        // Refresh first, then write, then read; hold only gates accesses.
        if (rfPend_r) begin
          state_nxt = fdc_pkg::FDC_RF1;
        end else if (wrPend_r && !hold_r) begin
          state_nxt   = fdc_pkg::FDC_ROW;
          opWrite_nxt = 1'b1;
          accEn_nxt   = 1'b1;
        end else if (rdPend_r && !hold_r) begin
          state_nxt   = fdc_pkg::FDC_ROW;
          opWrite_nxt = 1'b0;
          accEn_nxt   = 1'b1;
        end
      end
      fdc_pkg::FDC_ROW:  state_nxt = fdc_pkg::FDC_RAS;
      fdc_pkg::FDC_RAS:  state_nxt = fdc_pkg::FDC_COL;
      fdc_pkg::FDC_COL:  state_nxt = fdc_pkg::FDC_CAS1;
      fdc_pkg::FDC_CAS1: state_nxt = fdc_pkg::FDC_CAS2;
      fdc_pkg::FDC_CAS2: begin
        // Pointers advance only after the cycle so the address stays stable.
        state_nxt = fdc_pkg::FDC_IDLE;
        if (opWrite_r) begin
          wrPtr_nxt = wrPtr_r + 16'h0001;
        end else begin
          rdPtr_nxt = rdPtr_r + 16'h0001;
        end
      end
      fdc_pkg::FDC_RF1:  state_nxt = fdc_pkg::FDC_RF2;
      fdc_pkg::FDC_RF2:  state_nxt = fdc_pkg::FDC_IDLE;
    endcase
  end

  // Memory pins derived from the coming state; all strobes idle high.
  always_comb begin
    ptrNxt   = opWrite_nxt ? wrPtr_r : rdPtr_r;
    ras_nxt  = !(state_nxt inside {fdc_pkg::FDC_RAS, fdc_pkg::FDC_COL,
                                   fdc_pkg::FDC_CAS1, fdc_pkg::FDC_CAS2,
                                   fdc_pkg::FDC_RF2});
    cas_nxt  = !(state_nxt inside {fdc_pkg::FDC_CAS1, fdc_pkg::FDC_CAS2,
                                   fdc_pkg::FDC_RF1, fdc_pkg::FDC_RF2});
    rcs_nxt  = !(state_nxt inside {fdc_pkg::FDC_COL, fdc_pkg::FDC_CAS1,
                                   fdc_pkg::FDC_CAS2});
    oe_nxt   = !(!opWrite_nxt && state_nxt inside {fdc_pkg::FDC_COL, fdc_pkg::FDC_CAS1,
                                                   fdc_pkg::FDC_CAS2});
    weP_nxt  = !(opWrite_nxt && state_nxt inside {fdc_pkg::FDC_COL, fdc_pkg::FDC_CAS1});
    // Refresh leaves the address alone: the memory supplies its own row.
    addr_nxt = addr_r;
    if (state_nxt inside {fdc_pkg::FDC_ROW, fdc_pkg::FDC_RAS}) begin
      addr_nxt = ptrNxt[7:0];
    end else if (!rcs_nxt) begin
      addr_nxt = ptrNxt[15:8];
    end
    // Ready stays low while the own request or any refresh is outstanding.
    rdy_nxt  = !(rdPend_nxt || rfPend_nxt);
    wrdy_nxt = !(wrPend_nxt || rfPend_nxt);
  end

  // The falling-edge half of write enable ends its low phase mid-cycle.
  always_comb begin
    weNeg_nxt = !(opWrite_r && state_r inside {fdc_pkg::FDC_RAS, fdc_pkg::FDC_COL});
  end

  // Fill counter steps one cycle after each access pulse.
  always_comb begin
    fill_nxt = fill_r;
    if (accEn_r) begin
      fill_nxt = opWrite_r ? fill_r + 16'h0001 : fill_r - 16'h0001;
    end
    empty_nxt = (fill_nxt == `FDC_FILL_EMPTY);
    full_nxt  = (fill_nxt == `FDC_FILL_FULL);
    half_nxt  = (fill_nxt == `FDC_FILL_HALF);
  end

  // Sequencer and datapath registers.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r   <= fdc_pkg::FDC_IDLE;
      rdPend_r  <= 1'b0;
      wrPend_r  <= 1'b0;
      rfPend_r  <= 1'b0;
      opWrite_r <= 1'b0;
      accEn_r   <= 1'b0;
      wrPtr_r   <= `FDC_CNT_RESET;
      rdPtr_r   <= `FDC_CNT_RESET;
      fill_r    <= `FDC_CNT_RESET;
      addr_r    <= 8'h00;
      ras_r     <= 1'b1;
      cas_r     <= 1'b1;
      rcs_r     <= 1'b1;
      oe_r      <= 1'b1;
      weP_r     <= 1'b1;
      rdy_r     <= 1'b1;
      wrdy_r    <= 1'b1;
      empty_r   <= 1'b1;
      full_r    <= 1'b0;
      half_r    <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      rdPend_r  <= rdPend_nxt;
      wrPend_r  <= wrPend_nxt;
      rfPend_r  <= rfPend_nxt;
      opWrite_r <= opWrite_nxt;
      accEn_r   <= accEn_nxt;
      wrPtr_r   <= wrPtr_nxt;
      rdPtr_r   <= rdPtr_nxt;
      fill_r    <= fill_nxt;
      addr_r    <= addr_nxt;
      ras_r     <= ras_nxt;
      cas_r     <= cas_nxt;
      rcs_r     <= rcs_nxt;
      oe_r      <= oe_nxt;
      weP_r     <= weP_nxt;
      rdy_r     <= rdy_nxt;
      wrdy_r    <= wrdy_nxt;
      empty_r   <= empty_nxt;
      full_r    <= full_nxt;
      half_r    <= half_nxt;
    end
  end

  // Falling-edge write-enable register.
  always_ff @(negedge clk_sys) begin
    if (!rst_n) begin
      weNeg_r <= 1'b1;
    end else begin
      weNeg_r <= weNeg_nxt;
    end
  end

  // Write enable is low only while both halves are low: edge three to the
  // falling edge after edge four. The two flops never change together.
  assign weN_o          = weP_r | weNeg_r;
  assign rasN_o         = ras_r;
  assign casN_o         = cas_r;
  assign rowColSel_o    = rcs_r;
  assign oeN_o          = oe_r;
  assign memAddr_o      = addr_r;
  assign readReady_o    = rdy_r;
  assign writeReady_o   = wrdy_r;
  assign accessEnable_o = accEn_r;
  assign fifoEmpty_o    = empty_r;
  assign fifoFull_o     = full_r;
  assign fifoHalf_o     = half_r;

  // AXI4-Lite slave: address and data latch independently, one answer at a time.
  logic        awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt, bv_r, bv_nxt;
  logic        arRdy_r, arRdy_nxt, rv_r, rv_nxt;
  logic        awRdy_r, awRdy_nxt, wRdy_r, wRdy_nxt;
  logic [7:0]  awAddr_r, awAddr_nxt;
  logic [31:0] wData_r, wData_nxt, rData_r, rData_nxt;
  logic [3:0]  wStrb_r, wStrb_nxt;
  logic [1:0]  bResp_r, bResp_nxt, rResp_r, rResp_nxt;

  always_comb begin
    awHeld_nxt = awHeld_r || (s_axi_awvalid && s_axi_awready);
    wHeld_nxt  = wHeld_r || (s_axi_wvalid && s_axi_wready);
    awAddr_nxt = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : awAddr_r;
    wData_nxt  = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wData_r;
    wStrb_nxt  = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : wStrb_r;
    bv_nxt     = bv_r && !s_axi_bready;
    bResp_nxt  = bResp_r;
    hold_nxt   = hold_r;
    if (awHeld_r && wHeld_r && !bv_r) begin
      awHeld_nxt = 1'b0;
      wHeld_nxt  = 1'b0;
      bv_nxt     = 1'b1;
      bResp_nxt  = `FDC_RESP_OKAY;
      if (awAddr_r == `FDC_OFF_CTRL) begin
        if (wStrb_r[0]) begin
          hold_nxt = wData_r[`FDC_CTRL_HOLD];
        end
      end else if (!(awAddr_r inside {`FDC_OFF_STATUS, `FDC_OFF_FILL, `FDC_OFF_PTRS})) begin
        bResp_nxt = `FDC_RESP_DECERR;
      end
    end
    // Read channel: one outstanding read, arready drops while rvalid stands.
    rv_nxt    = rv_r && !s_axi_rready;
    rData_nxt = rData_r;
    rResp_nxt = rResp_r;
    if (s_axi_arvalid && arRdy_r) begin
      rv_nxt    = 1'b1;
      rResp_nxt = `FDC_RESP_OKAY;
      rData_nxt = 32'h0000_0000;
      unique case (s_axi_araddr)
        `FDC_OFF_CTRL:   rData_nxt[`FDC_CTRL_HOLD] = hold_r;
        `FDC_OFF_STATUS: rData_nxt[6:0] = {state_r == fdc_pkg::FDC_IDLE, rfPend_r, wrPend_r,
                                           rdPend_r, full_r, half_r, empty_r};
        `FDC_OFF_FILL:   rData_nxt[15:0] = fill_r;
        `FDC_OFF_PTRS:   rData_nxt = {rdPtr_r, wrPtr_r};
        default:         rResp_nxt = `FDC_RESP_DECERR;
      endcase
    end
    arRdy_nxt = !rv_nxt;
    // Write channels reopen once the held beat is consumed and the answer is taken.
    awRdy_nxt = !awHeld_nxt && !bv_nxt;
    wRdy_nxt  = !wHeld_nxt && !bv_nxt;
  end

  // Bus registers.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      awHeld_r <= 1'b0;
      wHeld_r  <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r  <= 32'h0000_0000;
      wStrb_r  <= 4'h0;
      bv_r     <= 1'b0;
      bResp_r  <= `FDC_RESP_OKAY;
      hold_r   <= `FDC_CTRL_RESET;
      arRdy_r  <= 1'b0;
      awRdy_r  <= 1'b0;
      wRdy_r   <= 1'b0;
      rv_r     <= 1'b0;
      rData_r  <= 32'h0000_0000;
      rResp_r  <= `FDC_RESP_OKAY;
    end else begin
      awHeld_r <= awHeld_nxt;
      wHeld_r  <= wHeld_nxt;
      awAddr_r <= awAddr_nxt;
      wData_r  <= wData_nxt;
      wStrb_r  <= wStrb_nxt;
      bv_r     <= bv_nxt;
      bResp_r  <= bResp_nxt;
      hold_r   <= hold_nxt;
      arRdy_r  <= arRdy_nxt;
      awRdy_r  <= awRdy_nxt;
      wRdy_r   <= wRdy_nxt;
      rv_r     <= rv_nxt;
      rData_r  <= rData_nxt;
      rResp_r  <= rResp_nxt;
    end
  end

  // Ready outputs are plain flop outputs so the master sees no combinational path.
  assign s_axi_awready = awRdy_r;
  assign s_axi_wready  = wRdy_r;
  assign s_axi_bvalid  = bv_r;
  assign s_axi_bresp   = bResp_r;
  assign s_axi_arready = arRdy_r;
  assign s_axi_rvalid  = rv_r;
  assign s_axi_rdata   = rData_r;
  assign s_axi_rresp   = rResp_r;

  // Checks on the memory sequence and the arbiter.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_ras_then_cas: assert property (state_r == fdc_pkg::FDC_RAS |-> !rasN_o && casN_o
    ##2 !casN_o && !rasN_o) else $error("Column strobe did not follow row strobe.");
  a_refresh_cbr: assert property (state_r == fdc_pkg::FDC_RF1 |-> !casN_o && rasN_o
    ##1 !casN_o && !rasN_o ##1 casN_o && rasN_o) else $error("Refresh strobe order wrong.");
  a_refresh_first: assert property (state_r == fdc_pkg::FDC_IDLE && rfPend_r
    |=> state_r == fdc_pkg::FDC_RF1) else $error("Refresh not served first.");
  a_write_before_read: assert property (state_r == fdc_pkg::FDC_IDLE && wrPend_r
    && !rfPend_r && !hold_r |=> opWrite_r && accessEnable_o) else $error("Write not served before read.");
  a_ready_in_refresh: assert property (rfPend_r |-> !readReady_o && !writeReady_o)
    else $error("Ready high during refresh.");
  a_fill_step: assert property (accessEnable_o && opWrite_r
    |=> fill_r == $past(fill_r) + 16'h0001) else $error("Fill count did not step up.");
  a_empty_flag: assert property ($rose(fifoEmpty_o) |-> fill_r == `FDC_FILL_EMPTY)
    else $error("Empty flag without zero fill.");
  a_strobe_release: assert property (state_r == fdc_pkg::FDC_CAS1 |-> !casN_o ##1 !casN_o
    ##1 casN_o && rasN_o) else $error("Strobes not released together.");
  a_idle_high: assert property (state_r == fdc_pkg::FDC_IDLE
    |-> rasN_o && casN_o && rowColSel_o) else $error("Strobes low while idle.");
  a_read_oe: assert property (state_r == fdc_pkg::FDC_COL && !opWrite_r
    |-> !oeN_o && weN_o && $past(!rasN_o)) else $error("Read output enable wrong.");
  a_col_addr: assert property (state_r == fdc_pkg::FDC_COL
    |-> memAddr_o == (opWrite_r ? wrPtr_r[15:8] : rdPtr_r[15:8])) else $error("Column address wrong.");
  a_pend_clear: assert property (done && opWrite_r && !wrEvt |=> !wrPend_r)
    else $error("Write request not cleared.");

  c_write_cycle: cover property (state_r == fdc_pkg::FDC_CAS2 && opWrite_r);
  c_read_cycle: cover property (state_r == fdc_pkg::FDC_CAS2 && !opWrite_r);
  c_refresh: cover property (state_r == fdc_pkg::FDC_RF2);
  c_three_pending: cover property (rfPend_r && wrPend_r && rdPend_r);

endmodule : fdc_controller

/* sim/fdc_dram_model.sv */
`timescale 1ns/1ps

// Memory array model: decodes strobe sequences into one record per closed cycle.
module fdc_dram_model (
  // Memory pins.
  input  wire logic        rasN,
  input  wire logic        casN,
  input  wire logic        weN,
  input  wire logic        oeN,
  input  wire logic [7:0]  memAddr,
  // Decoded records.
  output logic      [17:0] lastCycle,
  output logic      [15:0] cycleCount,
  output logic      [7:0]  errCount
);
  logic [7:0] rowR = 8'h0;
  logic [7:0] colR = 8'h0;
  logic [1:0] kindR = 2'h0;
  logic       casSeen = 1'b0;
  logic       armed = 1'b0;

  // Outputs start clean; the pins are unknown until the first reset edge.
  initial begin
    lastCycle = 18'h0;
    cycleCount = 16'h0;
    errCount = 8'h0;
  end

  // Row strobe falling: with the column strobe high it opens an access, with it low a refresh.
  always @(negedge rasN) begin
    armed = 1'b1;
    casSeen = 1'b0;
    rowR = memAddr;
    kindR = casN ? 2'h0 : 2'h3;
  end

  // Column strobe inside an open row takes the column and the direction from the enables.
  always @(negedge casN) begin
    if (!rasN) begin
      casSeen = 1'b1;
      colR = memAddr;
      kindR = !weN ? 2'h1 : (!oeN ? 2'h2 : 2'h0);
    end
  end

  // Closing row strobe publishes the record; a refresh is recorded with zero row and column.
  always @(posedge rasN) begin
    if (armed) begin
      if (kindR != 2'h3 && !casSeen) errCount = errCount + 8'h1;
      lastCycle = (kindR == 2'h3) ? {kindR, 16'h0} : {kindR, rowR, colR};
      cycleCount = cycleCount + 16'h1;
      armed = 1'b0;
    end
  end
endmodule : fdc_dram_model

/* sim/test_fdc_controller.sv */
`timescale 1ns/1ps
`include "fdc_map.svh"

`define CHK(got, exp) begin checksDone++; if ((got) !== (exp)) begin failCount++; \
  $display("MISMATCH t=%0t got %h want %h", $time, (got), (exp)); end end

module test_fdc_controller;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        read_request_n = 1'b1, write_request_n = 1'b1, refresh_request = 1'b0;
  logic        rdyRd, rdyWr, accEn, full, empty, half, rcSel, rasN, casN, weN, oeN;
  logic [7:0]  memAddr;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [17:0] lastCycle;
  logic [15:0] cycleCount, seenCount = 16'h0, wp = 16'h0, rp = 16'h0, fill = 16'h0;
  logic [7:0]  errCount;
  logic [33:0] axiQ[$];
  logic [17:0] memQ[$];
  logic [17:0] memE;
  logic [33:0] e;
  logic [31:0] seed = 32'h8c31e31c;
  int          failCount = 0, checksDone = 0, aeCount = 0, grants = 0, k;

  fdc_controller dut (.clk_sys, .rst_n, .read_request_n, .write_request_n, .refresh_request,
    .readReady_o(rdyRd), .writeReady_o(rdyWr), .accessEnable_o(accEn), .fifoFull_o(full),
    .fifoEmpty_o(empty), .fifoHalf_o(half), .memAddr_o(memAddr), .rowColSel_o(rcSel),
    .rasN_o(rasN), .casN_o(casN), .weN_o(weN), .oeN_o(oeN), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  fdc_dram_model mem (.rasN(rasN), .casN(casN), .weN(weN), .oeN(oeN), .memAddr(memAddr),
    .lastCycle(lastCycle), .cycleCount(cycleCount), .errCount(errCount));

  // Free-running system clock.
  always #5 clk_sys = ~clk_sys;

  // Pseudo-random source with a fixed start so every run is the same.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Prints the verdict and ends the run.
  task automatic conclude();
    if (failCount == 0 && checksDone > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  // A wait that uses up its bound is a failure in its own right.
  task automatic hang();
    failCount++;
    $display("MISMATCH t=%0t wait ran out", $time);
    conclude();
  endtask : hang

  // Notes the record the memory should see and steps the bench's own pointer model.
  task automatic note(input logic [1:0] kind);
    if (kind == 2'h1) begin
      memQ.push_back({kind, wp[7:0], wp[15:8]});
      wp++; fill++; grants++;
    end else if (kind == 2'h2) begin
      memQ.push_back({kind, rp[7:0], rp[15:8]});
      rp++; fill--; grants++;
    end else memQ.push_back({kind, 16'h0});
  endtask : note

  // One register write; address and data go out together, each dropped once taken.
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    int n;
    @(posedge clk_sys);
    axiQ.push_back({resp, 32'h0});
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 50) hang();
  endtask : axiWrite

  // One register read; the answer is compared by the watcher.
  task automatic axiRead(input logic [7:0] a, input logic [33:0] exp);
    int n;
    @(posedge clk_sys);
    axiQ.push_back(exp);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 50) hang();
  endtask : axiRead

  // Asserts the chosen request pins together and holds them past the input synchroniser.
  task automatic fire(input logic wr, input logic rd, input logic rf);
    @(posedge clk_sys);
    write_request_n <= ~wr; read_request_n <= ~rd; refresh_request <= rf;
    repeat (4) @(posedge clk_sys);
    if (wr) `CHK(rdyWr, 1'b0)
    if (rf) `CHK({rdyRd, rdyWr}, 2'b00)
    write_request_n <= 1'b1; read_request_n <= 1'b1; refresh_request <= 1'b0;
  endtask : fire

  // Waits for every noted record and both ready outputs; the requester keeps this order.
  task automatic settle();
    int n;
    for (n = 0; n < 100; n++) begin
      @(posedge clk_sys);
      if (memQ.size() == 0 && rdyRd === 1'b1 && rdyWr === 1'b1) break;
    end
    if (n == 100) hang();
  endtask : settle

  // Reads back fill count, pointers and flags against the bench's model.
  task automatic status();
    axiRead(`FDC_OFF_FILL, {`FDC_RESP_OKAY, 16'h0, fill});
    axiRead(`FDC_OFF_PTRS, {`FDC_RESP_OKAY, rp, wp});
    axiRead(`FDC_OFF_STATUS, {`FDC_RESP_OKAY, 25'h0, 4'h8, fill == 16'hffff, fill == 16'h7fff,
      fill == 16'h0});
    `CHK({full, half, empty}, {fill == 16'hffff, fill == 16'h7fff, fill == 16'h0})
  endtask : status

  // Watcher: takes the oldest note whenever the bus answers or the memory closes a cycle.
  always @(posedge clk_sys) begin
    if (accEn === 1'b1) aeCount++;
    if (s_axi_rvalid && s_axi_rready) begin
      e = axiQ.pop_front();
      if (e[33:32] == `FDC_RESP_DECERR) `CHK(s_axi_rresp, e[33:32])
      else `CHK({s_axi_rresp, s_axi_rdata}, e)
    end
    if (s_axi_bvalid && s_axi_bready) begin
      e = axiQ.pop_front();
      `CHK(s_axi_bresp, e[33:32])
    end
    if (cycleCount != seenCount) begin
      seenCount <= cycleCount;
      memE = memQ.pop_front();
      `CHK(lastCycle, memE)
    end
  end

  // Hard stop should anything wedge outside the bounded waits.
  initial begin
    repeat (20000) @(posedge clk_sys);
    hang();
  end

  // Main sequence.
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    `CHK({rdyRd, rdyWr, empty, full, half}, 5'b11100)
    `CHK({rasN, casN, weN, oeN, rcSel}, 5'h1f)
    status();
    axiWrite(8'h10, rnd(), `FDC_RESP_DECERR);
    axiRead(8'h14, {`FDC_RESP_DECERR, 32'h0});
    axiWrite(`FDC_OFF_STATUS, rnd(), `FDC_RESP_OKAY);
    // A control write without byte lane 0 must leave the hold bit alone.
    s_axi_wstrb <= 4'he;
    axiWrite(`FDC_OFF_CTRL, 32'h1, `FDC_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    axiRead(`FDC_OFF_CTRL, {`FDC_RESP_OKAY, 32'h0});
    repeat (3 + int'(rnd() % 32'h4)) begin
      note(2'h1);
      fire(1'b1, 1'b0, 1'b0);
      settle();
    end
    status();
    // All three at once, then write against read.
    note(2'h3); note(2'h1); note(2'h2);
    fire(1'b1, 1'b1, 1'b1);
    settle();
    note(2'h1); note(2'h2);
    fire(1'b1, 1'b1, 1'b0);
    settle();
    // Hold blocks the access grant while a refresh still runs.
    axiWrite(`FDC_OFF_CTRL, 32'h1, `FDC_RESP_OKAY);
    note(2'h3); note(2'h1);
    fire(1'b1, 1'b0, 1'b0);
    fire(1'b0, 1'b0, 1'b1);
    repeat (20) @(posedge clk_sys);
    `CHK({memQ.size() == 1, rdyWr}, 2'b10)
    axiWrite(`FDC_OFF_CTRL, 32'h0, `FDC_RESP_OKAY);
    settle();
    status();
    // Drain to empty, then one read past empty wraps the count to full.
    for (k = 0; k < 20 && fill != 16'h0; k++) begin
      note(2'h2);
      fire(1'b0, 1'b1, 1'b0);
      settle();
    end
    status();
    note(2'h2);
    fire(1'b0, 1'b1, 1'b0);
    settle();
    status();
    // A reset in mid-run must clear both pointers and the fill count.
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    wp = 16'h0;
    rp = 16'h0;
    fill = 16'h0;
    repeat (2) @(posedge clk_sys);
    `CHK({rasN, casN, weN, oeN, rcSel, rdyRd, rdyWr}, 7'h7f)
    status();
    `CHK(aeCount, grants)
    `CHK(errCount, 8'h0)
    conclude();
  end
endmodule : test_fdc_controller
